/* File: verilog/psag_pkg.sv */
// Constants for the program space address generator.
// Assumes a 32-bit classic Wishbone slave port and one core clock.
package psag_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_TABLE_PAGE  = 8'h00;
    localparam logic [7:0] OFS_VIS_PAGE    = 8'h04;
    localparam logic [7:0] OFS_PROC_CTRL   = 8'h08;
    localparam logic [7:0] OFS_STATUS      = 8'h0c;
    localparam logic [7:0] OFS_LAST_ADDR   = 8'h10;

    // Field positions
    localparam int VIS_EN_BIT      = 2;
    localparam int CFG_SEL_BIT     = 7;
    localparam int STAT_CFG_WR_BIT = 0;
    localparam int STAT_VIS_WR_BIT = 1;
    localparam int STAT_FLAGS      = 2;
    localparam int PROG_ADDR_W     = 24;
    localparam int EA_WIDTH        = 16;
    localparam int PAGE_WIDTH      = 8;

    // Reset values
    localparam logic [7:0]  RST_TABLE_PAGE = 8'h00;
    localparam logic [7:0]  RST_VIS_PAGE   = 8'h00;
    localparam logic [7:0]  RST_PROC_CTRL  = 8'h00;
    localparam logic [1:0]  RST_STATUS     = 2'h0;
    localparam logic [23:0] RST_ADDR       = 24'h000000;

    // Access kind codes on the core port
    localparam logic [1:0] KIND_FETCH = 2'h0;
    localparam logic [1:0] KIND_DATA  = 2'h1;
    localparam logic [1:0] KIND_TABLE = 2'h2;

    // Internal access class
    typedef enum logic [2:0] {
        PSAG_CL_IDLE,
        PSAG_CL_FETCH,
        PSAG_CL_TABLE,
        PSAG_CL_VIS,
        PSAG_CL_DATA,
        PSAG_CL_BAD
    } psag_class_t;
endpackage : psag_pkg

/* File: verilog/psag_core.sv */
// Program space address generator: table, visibility and fetch paths.
// Assumes core requests synchronous to clk_i, one request per cycle at most,
// and a classic Wishbone master for the page and control registers.
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RULE1: Table access address is table page above the 16-bit effective address.
// RULE2: Table page top bit picks user (0) or configuration (1) space.
// RULE3: Effective address top bit set gives visibility page joined to low 15 bits.
// RULE4: Visibility page picks one 16K-word program page for the data window.
// RULE5: Visibility accesses reach user memory only; address bit 23 is zero.
// RULE6: Effective bit 15 ignored; program bit 15 comes from visibility page bit 0.
// RULE7: Fetch and visibility addresses have the least significant bit forced zero.
// RULE8: Table accesses accept any byte address, no alignment check.
// RULE9: Table reads may target configuration space.
// RULE10: Visibility path is read-only, returning only the low program word.
// RULE11: Table writes aimed at configuration space are refused.
// RULE12: Visibility window active only when enable bit set and top bit one.
module psag_core #(
    parameter int EA_W   = 16,
    parameter int PAGE_W = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Core access port
    input  wire logic        req_i,
    input  wire logic [1:0]  kind_i,
    input  wire logic        write_i,
    input  wire logic [15:0] ea_i,
    input  wire logic [23:0] pc_i,
    // Program memory side
    output logic             pm_valid_o,
    output logic [23:0]      pm_addr_o,
    output logic             pm_write_o,
    output logic             pm_config_o,
    output logic             pm_low_word_o,
    output logic             pm_refused_o,
    output logic             data_pass_o
);

    generate
        if (EA_W != psag_pkg::EA_WIDTH || PAGE_W != psag_pkg::PAGE_WIDTH) begin : g_bad
            $error("psag_core supports only 16-bit addresses and 8-bit pages");
        end
    endgenerate

    logic [7:0]  table_page_reg_r;
    logic [7:0]  visibility_page_reg_r;
    logic [7:0]  processor_control_reg_r;
    logic [psag_pkg::STAT_FLAGS-1:0] status_r;
    logic [23:0] last_addr_r;
    logic        ack_r;
    logic [31:0] dat_r;

    logic        bus_req;
    logic        bus_wr;
    logic        bus_rd;
    logic        visibility_enable;
    psag_pkg::psag_class_t cls;
    logic [23:0] addr_nxt;
    logic        refuse_nxt;
    logic        cfg_wr_evt;
    logic        vis_wr_evt;
    logic [psag_pkg::STAT_FLAGS-1:0] evt;
    logic [psag_pkg::STAT_FLAGS-1:0] clr;

    assign bus_req           = cyc_i && stb_i && !ack_r;
    assign bus_wr            = bus_req && we_i && sel_i[0];
    assign bus_rd            = bus_req && !we_i;
    assign visibility_enable = processor_control_reg_r[psag_pkg::VIS_EN_BIT];

    // Classify each core request
    always_comb begin
        cls = psag_pkg::PSAG_CL_IDLE;
        if (req_i) begin
            case (kind_i)
                psag_pkg::KIND_FETCH: cls = psag_pkg::PSAG_CL_FETCH;
                psag_pkg::KIND_TABLE: cls = psag_pkg::PSAG_CL_TABLE;
                // RULE12: window gate
                psag_pkg::KIND_DATA: begin
                    if (visibility_enable && ea_i[15]) begin
                        cls = psag_pkg::PSAG_CL_VIS;
                    end else begin
                        cls = psag_pkg::PSAG_CL_DATA;
                    end
                end
                default: cls = psag_pkg::PSAG_CL_BAD;
            endcase
        end
    end

    // Build the program address
    always_comb begin
        addr_nxt   = psag_pkg::RST_ADDR;
        refuse_nxt = 1'b0;
        case (cls)
            // RULE7: fetch alignment
            psag_pkg::PSAG_CL_FETCH: addr_nxt = {1'b0, pc_i[22:1], 1'b0};
            psag_pkg::PSAG_CL_TABLE: begin
                // RULE1: page over EA
                // RULE8: no alignment
                addr_nxt = {table_page_reg_r, ea_i};
                // RULE11: config write refused
                // RULE9: config reads pass
                refuse_nxt = write_i && table_page_reg_r[psag_pkg::CFG_SEL_BIT];
            end
            psag_pkg::PSAG_CL_VIS: begin
                // RULE3: page joined to EA
                // RULE4: 16K-word page
                // RULE5: user space only
                // RULE6: bit 15 from page
                // RULE7: word aligned
                addr_nxt = {1'b0, visibility_page_reg_r, ea_i[14:1], 1'b0};
                // RULE10: read-only window
                refuse_nxt = write_i;
            end
            psag_pkg::PSAG_CL_BAD: refuse_nxt = 1'b1;
            default: addr_nxt = psag_pkg::RST_ADDR;
        endcase
    end

    assign cfg_wr_evt = (cls == psag_pkg::PSAG_CL_TABLE) && refuse_nxt;
    assign vis_wr_evt = (cls == psag_pkg::PSAG_CL_VIS) && refuse_nxt;
    assign evt        = {vis_wr_evt, cfg_wr_evt};
    assign clr        = (bus_wr && adr_i == psag_pkg::OFS_STATUS)
                        ? dat_i[psag_pkg::STAT_FLAGS-1:0] : '0;

    // Program memory outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pm_valid_o    <= 1'b0;
            pm_addr_o     <= psag_pkg::RST_ADDR;
            pm_write_o    <= 1'b0;
            pm_config_o   <= 1'b0;
            pm_low_word_o <= 1'b0;
            pm_refused_o  <= 1'b0;
            data_pass_o   <= 1'b0;
        end else begin
            pm_valid_o    <= (cls == psag_pkg::PSAG_CL_FETCH || cls == psag_pkg::PSAG_CL_TABLE
                              || cls == psag_pkg::PSAG_CL_VIS) && !refuse_nxt;
            pm_addr_o     <= addr_nxt;
            pm_write_o    <= (cls == psag_pkg::PSAG_CL_TABLE) && write_i && !refuse_nxt;
            // RULE2: space select
            pm_config_o   <= (cls == psag_pkg::PSAG_CL_TABLE)
                             && table_page_reg_r[psag_pkg::CFG_SEL_BIT];
            pm_low_word_o <= (cls == psag_pkg::PSAG_CL_VIS);
            pm_refused_o  <= refuse_nxt;
            data_pass_o   <= (cls == psag_pkg::PSAG_CL_DATA);
        end
    end

    // Last generated address, for software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_addr_r <= psag_pkg::RST_ADDR;
        end else if (cls == psag_pkg::PSAG_CL_FETCH || cls == psag_pkg::PSAG_CL_TABLE
                     || cls == psag_pkg::PSAG_CL_VIS) begin
            last_addr_r <= addr_nxt;
        end
    end

    // Sticky refusal flags, set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < psag_pkg::STAT_FLAGS; gi++) begin : g_flag
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    status_r[gi] <= psag_pkg::RST_STATUS[gi];
                end else if (evt[gi]) begin
                    status_r[gi] <= 1'b1;
                end else if (clr[gi]) begin
                    status_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Page and control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            table_page_reg_r        <= psag_pkg::RST_TABLE_PAGE;
            visibility_page_reg_r   <= psag_pkg::RST_VIS_PAGE;
            processor_control_reg_r <= psag_pkg::RST_PROC_CTRL;
        end else if (bus_wr) begin
            case (adr_i)
                psag_pkg::OFS_TABLE_PAGE: table_page_reg_r        <= dat_i[7:0];
                psag_pkg::OFS_VIS_PAGE:   visibility_page_reg_r   <= dat_i[7:0];
                psag_pkg::OFS_PROC_CTRL:  processor_control_reg_r <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Bus answer, one wait cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h00000000;
        end else if (bus_rd) begin
            case (adr_i)
                psag_pkg::OFS_TABLE_PAGE: dat_r <= {24'h000000, table_page_reg_r};
                psag_pkg::OFS_VIS_PAGE:   dat_r <= {24'h000000, visibility_page_reg_r};
                psag_pkg::OFS_PROC_CTRL:  dat_r <= {24'h000000, processor_control_reg_r};
                psag_pkg::OFS_STATUS:     dat_r <= {30'h00000000, status_r};
                psag_pkg::OFS_LAST_ADDR:  dat_r <= {8'h00, last_addr_r};
                default:                  dat_r <= 32'h00000000;
            endcase
        end else begin
            dat_r <= 32'h00000000;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // Checks
    sequence s_tab_req;
        req_i && kind_i == psag_pkg::KIND_TABLE;
    endsequence

    sequence s_vis_req;
        req_i && kind_i == psag_pkg::KIND_DATA && visibility_enable && ea_i[15];
    endsequence

    sequence s_fetch_req;
        req_i && kind_i == psag_pkg::KIND_FETCH;
    endsequence

    sequence s_bad_req;
        req_i && kind_i == 2'h3;
    endsequence

    sequence s_user_wr;
        s_tab_req ##0 (write_i && !table_page_reg_r[psag_pkg::CFG_SEL_BIT]);
    endsequence

    AST_TABLE_ADDR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        s_tab_req |=> pm_addr_o == {$past(table_page_reg_r), $past(ea_i)})
        else $error("table address not page over ea");

    AST_TABLE_SPACE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        s_tab_req |=> pm_config_o == $past(table_page_reg_r[7]))
        else $error("table space select wrong");

    AST_VIS_ADDR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        s_vis_req |=> pm_addr_o[22:15] == $past(visibility_page_reg_r)
                      && pm_addr_o[14:1] == $past(ea_i[14:1]))
        else $error("visibility address not page joined to ea");

    AST_VIS_PAGE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        s_vis_req |=> pm_addr_o[15] == $past(visibility_page_reg_r[0]) && pm_low_word_o)
        else $error("visibility page bit not placed");

    AST_VIS_USER: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        s_vis_req |=> !pm_addr_o[23] && !pm_config_o)
        else $error("visibility reached configuration space");

    AST_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        (s_vis_req or s_fetch_req) |=> !pm_addr_o[0])
        else $error("address lsb not zero");

    AST_BYTE_TABLE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        (s_tab_req ##0 (!write_i && ea_i[0])) |=> pm_valid_o && pm_addr_o[0])
        else $error("odd table read lost");

    AST_CFG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        (s_tab_req ##0 (write_i && table_page_reg_r[7]))
        |=> pm_refused_o && !pm_write_o && !pm_valid_o && status_r[0])
        else $error("config write not refused");

    AST_CFG_READ: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        (s_tab_req ##0 (!write_i && table_page_reg_r[7])) |=> pm_valid_o && pm_config_o)
        else $error("config read refused");

    AST_VIS_RO: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        (s_vis_req ##0 write_i) |=> pm_refused_o && !pm_write_o && status_r[1])
        else $error("visibility write not refused");

    AST_WINDOW_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        (req_i && kind_i == psag_pkg::KIND_DATA && !(visibility_enable && ea_i[15]))
        |=> data_pass_o && !pm_valid_o)
        else $error("window open without enable");

    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held two cycles");

    AST_VIS_EA15: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        s_vis_req |=> pm_addr_o[15] == $past(visibility_page_reg_r[0]))
        else $error("visibility bit 15 not from page bit 0");

    AST_FETCH_ADDR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        s_fetch_req |=> pm_valid_o && pm_addr_o == {1'b0, $past(pc_i[22:1]), 1'b0})
        else $error("fetch address wrong");

    AST_USER_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        s_user_wr |=> pm_valid_o && pm_write_o && !pm_refused_o && !pm_config_o)
        else $error("user table write not passed");

    AST_BAD_KIND: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bad_req |=> pm_refused_o && !pm_valid_o && !pm_write_o)
        else $error("illegal access kind not refused");

    AST_IDLE_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        !req_i |=> !pm_valid_o && !pm_refused_o && !data_pass_o && !pm_low_word_o)
        else $error("program memory strobe without request");

    AST_TABLE_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        s_tab_req |=> !pm_low_word_o && !data_pass_o)
        else $error("table access shown as data access");

    AST_VIS_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        s_vis_req |=> pm_low_word_o && !pm_write_o && !pm_config_o)
        else $error("visibility access not low word read");

    AST_ACK_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("bus request not answered after one wait cycle");

    AST_DAT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        !ack_o |-> dat_o == 32'h00000000)
        else $error("read data shown outside an answer");

    AST_LAST_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_tab_req or s_vis_req or s_fetch_req) |=> last_addr_r == pm_addr_o)
        else $error("last address not recorded");

endmodule : psag_core

`default_nettype wire

/* File: testbench/psag_core_model.sv */
// Core-side stand-in: issues one table, data or fetch access per call.
// Assumes the caller runs in a procedural thread clocked by clk_i.
`timescale 1ns/1ns
`default_nettype none
module psag_core_model (
    input  wire logic        clk_i,
    output logic             req_o,
    output logic [1:0]       kind_o,
    output logic             write_o,
    output logic [15:0]      ea_o,
    output logic [23:0]      pc_o
);
    initial begin
        req_o = 1'b0;
        kind_o = 2'h0;
        write_o = 1'b0;
        ea_o = 16'h0000;
        pc_o = 24'h000000;
    end

    task automatic issue(input logic [1:0] k, input logic w, input logic [15:0] ea,
                         input logic [23:0] pc);
        @(posedge clk_i);
        req_o   <= 1'b1;
        kind_o  <= k;
        write_o <= w;
        ea_o    <= ea;
        pc_o    <= pc;
        @(posedge clk_i);
        req_o   <= 1'b0;
        // Released lines show no stale value
        kind_o  <= ~k;
        write_o <= ~w;
        ea_o    <= ~ea;
        pc_o    <= ~pc;
    endtask : issue
endmodule : psag_core_model
`default_nettype wire

/* File: testbench/psag_core_tb.sv */
// Self-checking bench for the program space address generator.
// Assumes psag_core, psag_pkg and psag_core_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module psag_core_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, dat_o;
    logic ack_o, req, core_wr, pm_valid_o, pm_write_o, pm_config_o, pm_low_word_o;
    logic pm_refused_o, data_pass_o;
    logic [1:0]  kind;
    logic [15:0] ea;
    logic [23:0] pc, pm_addr_o;
    int n_mismatch = 0, check_count = 0;

    always #2 clk_i = ~clk_i;

    psag_core_model m (.clk_i(clk_i), .req_o(req), .kind_o(kind), .write_o(core_wr), .ea_o(ea),
                       .pc_o(pc));
    psag_core DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
                   .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
                   .req_i(req), .kind_i(kind), .write_i(core_wr), .ea_i(ea), .pc_i(pc),
                   .pm_valid_o(pm_valid_o), .pm_addr_o(pm_addr_o), .pm_write_o(pm_write_o),
                   .pm_config_o(pm_config_o), .pm_low_word_o(pm_low_word_o),
                   .pm_refused_o(pm_refused_o), .data_pass_o(data_pass_o));

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            #1;
        end while (ack_o !== 1'b1);
        q = dat_o;
        @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, {24'h0, d}, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd

    // Flags: valid, write, config, low word, refused, data pass
    task automatic acc(input logic [1:0] k, input logic w, input logic [15:0] e,
                       input logic [23:0] p, input logic [23:0] ad, input logic [5:0] fl);
        m.issue(k, w, e, p);
        #1;
        chk({26'h0, pm_valid_o, pm_write_o, pm_config_o, pm_low_word_o, pm_refused_o,
             data_pass_o}, {26'h0, fl});
        if (fl[5]) chk({8'h0, pm_addr_o}, {8'h0, ad});
    endtask : acc

    task automatic t_regs();
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h00, 8'ha5);
        rd(8'h00, 32'ha5);
        $display("done regs");
    endtask : t_regs

    task automatic t_table();
        wr(8'h00, 8'h01);
        acc(2'h2, 1'b0, 16'h1235, 24'h0, 24'h011235, 6'b100000);
        acc(2'h2, 1'b1, 16'h4001, 24'h0, 24'h014001, 6'b110000);
        wr(8'h00, 8'h81);
        acc(2'h2, 1'b0, 16'h0003, 24'h0, 24'h810003, 6'b101000);
        acc(2'h2, 1'b1, 16'h0003, 24'h0, 24'h0, 6'b001010);
        rd(8'h0c, 32'h1);
        wr(8'h0c, 8'h01);
        rd(8'h0c, 32'h0);
        acc(2'h3, 1'b0, 16'h0000, 24'h0, 24'h0, 6'b000010);
        $display("done table");
    endtask : t_table

    task automatic t_vis();
        wr(8'h08, 8'h04);
        wr(8'h04, 8'h03);
        acc(2'h1, 1'b0, 16'h8003, 24'h0, 24'h018002, 6'b100100);
        wr(8'h04, 8'hff);
        acc(2'h1, 1'b0, 16'hffff, 24'h0, 24'h7ffffe, 6'b100100);
        rd(8'h10, 32'h7ffffe);
        acc(2'h1, 1'b1, 16'h8004, 24'h0, 24'h0, 6'b000110);
        rd(8'h0c, 32'h2);
        acc(2'h1, 1'b0, 16'h1000, 24'h0, 24'h0, 6'b000001);
        wr(8'h08, 8'h00);
        acc(2'h1, 1'b0, 16'h8003, 24'h0, 24'h0, 6'b000001);
        $display("done visibility");
    endtask : t_vis

    task automatic t_fetch();
        acc(2'h0, 1'b0, 16'h0, 24'habcdef, 24'h2bcdee, 6'b100000);
        rd(8'h10, 32'h2bcdee);
        $display("done fetch");
    endtask : t_fetch

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_table();
        t_vis();
        t_fetch();
        summarize();
    end

    initial begin
        #20000;
        n_mismatch++;
        summarize();
    end
endmodule : psag_core_tb
`default_nettype wire
